// file: rtl/uartlf_pkg.sv
// Behaviour
// - Parity bit set makes parity even; clear makes it odd, both directions.
// - Transmitter sends computed parity bit as last bit of each character.
// - Receiver checks parity; mismatch flags status and entry bit 8.
// - Stop select clear: one stop bit sent, one checked by receiver.
// - Depth enable set uses all 16 entries; clear uses one entry only.
// - Single-entry mode raises service request per frame received or sent.
// - Full FIFO mode uses half full, 8 of 16, for service requests.
// - Length field 11/10/01/00 selects eight/seven/six/five data bits.
// - Short characters are right aligned with zero upper bits.
// - Divisor is 12 bits: high nibble register plus low byte register.
// - Bit rate equals clock over 4 over 16 times divisor plus one.
// - Divisor gives 4096 rates; fastest is clock over 64, 312.5 Kbps at the bench's 20 MHz.
// - Control and divisor form one 19-bit register loaded on control write.
// - Parity check enable gates only the receive check.
package uartlf_pkg;
	// Register byte addresses
	localparam logic [11:0] ADDR_DATA   = 12'h160;
	localparam logic [11:0] ADDR_RXSTAT = 12'h164;
	localparam logic [11:0] ADDR_LFC    = 12'h168;
	localparam logic [11:0] ADDR_DIVHI  = 12'h16c;
	localparam logic [11:0] ADDR_DIVLO  = 12'h170;
	localparam logic [11:0] ADDR_CTRL   = 12'h174;
	localparam logic [11:0] ADDR_FLAG   = 12'h178;
	// Line format control fields
	localparam int LFC_BREAK = 0;
	localparam int LFC_PCHK  = 1;
	localparam int LFC_EVEN  = 2;
	localparam int LFC_STOP2 = 3;
	localparam int LFC_FIFO  = 4;
	localparam int LFC_LEN   = 5;
	localparam int LFC_W     = 7;
	localparam int DIV_W     = 12;
	localparam int COMB_W    = 19;
	localparam logic [COMB_W-1:0] COMB_RST = 19'h0;
	// Receive entry and status fields
	localparam int RXE_W    = 10;
	localparam int RXE_PERR = 8;
	localparam int RXE_FERR = 9;
	localparam int ST_FERR  = 0;
	localparam int ST_PERR  = 1;
	localparam int ST_OVR   = 2;
	localparam int FLG_TBUSY = 3;
	localparam int FLG_RXEMP = 4;
	localparam int FLG_TXFUL = 5;
	localparam int CTRL_EN   = 0;
	// FIFO sizing
	localparam int FIFO_DEPTH = 16;
	localparam int LVL_W      = 5;
	localparam logic [LVL_W-1:0] FIFO_HALF = 5'h08;
	// Rate timing: prescale by 4, 16 ticks per bit, sample at mid bit
	localparam logic [1:0] PRE_LAST = 2'h3;
	localparam logic [3:0] TK_LAST  = 4'hf;
	localparam logic [3:0] TK_MID   = 4'h7;
	typedef enum logic [2:0] {PH_IDLE, PH_START, PH_DATA, PH_PARITY, PH_STOP} uartlf_phase_type;
endpackage : uartlf_pkg

// file: rtl/uartlf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module uartlf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int LW    = 5
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic             single,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [LW-1:0]         level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [LW-1:0]               cnt;
	} uartlf_fifo_state_type;
	uartlf_fifo_state_type st_r;
	uartlf_fifo_state_type st_nxt;
	logic push;
	logic pop;

	// Single mode caps occupancy at one entry
	assign in_ready  = single ? (st_r.cnt == '0) : (st_r.cnt != LW'(DEPTH));
	assign out_valid = st_r.cnt != '0;
	assign out_data  = st_r.mem[st_r.rd];
	assign level     = st_r.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap naturally, depth is a power of two
	always_comb
	begin
		st_nxt = st_r;
		if (push)
		begin
			st_nxt.mem[st_r.wr] = in_data;
			st_nxt.wr = st_r.wr + AW'(1);
		end
		if (pop)
			st_nxt.rd = st_r.rd + AW'(1);
		st_nxt.cnt = st_r.cnt + LW'(push) - LW'(pop);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end
endmodule : uartlf_fifo
`default_nettype wire

// file: rtl/uartlf_rate.sv
`timescale 1ns/1ps
`default_nettype none
module uartlf_rate (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic [11:0] divisor,
	output logic             tick
);
	typedef struct packed {
		logic [1:0]  pre;
		logic [11:0] cnt;
		logic        tick;
	} uartlf_rate_state_type;
	uartlf_rate_state_type st_r;
	uartlf_rate_state_type st_nxt;

	assign tick = st_r.tick;

	// One tick every 4*(divisor+1) clocks, 16 ticks per bit
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.pre != uartlf_pkg::PRE_LAST)
			st_nxt.pre = st_r.pre + 2'h1;
		else
		begin
			st_nxt.pre = 2'h0;
			if (st_r.cnt == 12'h000)
			begin
				st_nxt.cnt = divisor;
				st_nxt.tick = 1'b1;
			end
			else
				st_nxt.cnt = st_r.cnt - 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end
endmodule : uartlf_rate
`default_nettype wire

// file: rtl/uartlf_top.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module uartlf_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	output logic             rx_service_request,
	output logic             tx_service_request
);
	typedef struct packed {
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
		logic                         rdv;
		logic [7:0]                   div_lo;
		logic [3:0]                   div_hi;
		logic [uartlf_pkg::COMB_W-1:0] comb;
		logic                         en;
		logic [2:0]                   stat;
		logic                         rxs1;
		logic                         rxs2;
		uartlf_pkg::uartlf_phase_type tx_ph;
		logic [3:0]                   tx_tk;
		logic [2:0]                   tx_bit;
		logic [7:0]                   tx_sh;
		logic                         tx_stop2;
		logic                         txd;
		uartlf_pkg::uartlf_phase_type rx_ph;
		logic [3:0]                   rx_tk;
		logic [2:0]                   rx_bit;
		logic [7:0]                   rx_sh;
		logic                         rx_perr;
		logic                         rx_push;
		logic [uartlf_pkg::RXE_W-1:0] rx_word;
		logic                         rxreq;
		logic                         txreq;
	} uartlf_top_state_type;
	uartlf_top_state_type st_r;
	uartlf_top_state_type st_nxt;

	logic [uartlf_pkg::LFC_W-1:0] lfc;
	logic [1:0]                   len;
	logic [2:0]                   last_bit;
	logic                         even;
	logic                         stop2;
	logic                         fifo_en;
	logic                         pchk;
	logic                         brk;
	logic                         setup;
	logic                         access;
	logic                         tick;
	logic                         tx_push;
	logic                         tx_pop;
	logic                         rx_pop;
	logic                         txq_ready;
	logic                         txq_valid;
	logic [7:0]                   txq_data;
	logic [uartlf_pkg::LVL_W-1:0] txq_level;
	logic                         rxq_ready;
	logic                         rxq_valid;
	logic [uartlf_pkg::RXE_W-1:0] rxq_data;
	logic [uartlf_pkg::LVL_W-1:0] rxq_level;

	// Keep only the selected number of data bits
	function automatic logic [7:0] len_mask(input logic [7:0] d, input logic [1:0] l);
		len_mask = d & (8'hff >> (2'h3 - l));
	endfunction : len_mask

	// Parity bit that makes the chosen total parity
	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] l, input logic ev);
		par_bit = ev ? ^len_mask(d, l) : ~^len_mask(d, l);
	endfunction : par_bit

	// Live format comes only from the committed register
	assign lfc      = st_r.comb[uartlf_pkg::COMB_W-1:uartlf_pkg::DIV_W];
	assign len      = lfc[uartlf_pkg::LFC_LEN +: 2];
	assign last_bit = {1'b0, len} + 3'h4;
	assign even     = lfc[uartlf_pkg::LFC_EVEN];
	assign stop2    = lfc[uartlf_pkg::LFC_STOP2];
	assign fifo_en  = lfc[uartlf_pkg::LFC_FIFO];
	assign pchk     = lfc[uartlf_pkg::LFC_PCHK];
	assign brk      = lfc[uartlf_pkg::LFC_BREAK];

	// Bus phase decode and FIFO handshakes
	assign setup   = psel && !penable;
	assign access  = psel && penable && st_r.pready;
	assign tx_push = access && pwrite && paddr == uartlf_pkg::ADDR_DATA;
	assign rx_pop  = access && !pwrite && paddr == uartlf_pkg::ADDR_DATA && st_r.rdv;
	assign tx_pop  = tick && st_r.en && !brk && st_r.tx_ph == uartlf_pkg::PH_IDLE && txq_valid;

	assign prdata             = st_r.prdata;
	assign pready             = st_r.pready;
	assign pslverr            = st_r.pslverr;
	assign txd                = st_r.txd;
	assign rx_service_request = st_r.rxreq;
	assign tx_service_request = st_r.txreq;

	uartlf_rate u_rate (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.divisor (st_r.comb[uartlf_pkg::DIV_W-1:0]),
		.tick    (tick)
	);

	// Both queues drop to one entry when depth enable is clear
	uartlf_fifo #(.WIDTH(8), .DEPTH(uartlf_pkg::FIFO_DEPTH), .LW(uartlf_pkg::LVL_W)) u_txq (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.single    (!fifo_en),
		.in_valid  (tx_push),
		.in_ready  (txq_ready),
		.in_data   (len_mask(pwdata[7:0], len)),
		.out_valid (txq_valid),
		.out_ready (tx_pop),
		.out_data  (txq_data),
		.level     (txq_level)
	);

	uartlf_fifo #(.WIDTH(uartlf_pkg::RXE_W), .DEPTH(uartlf_pkg::FIFO_DEPTH), .LW(uartlf_pkg::LVL_W)) u_rxq (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.single    (!fifo_en),
		.in_valid  (st_r.rx_push),
		.in_ready  (rxq_ready),
		.in_data   (st_r.rx_word),
		.out_valid (rxq_valid),
		.out_ready (rx_pop),
		.out_data  (rxq_data),
		.level     (rxq_level)
	);

	// Bus slave, transmitter, receiver and request logic
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.rx_push = 1'b0;
		// Zero-wait slave: answer prepared in setup
		if (setup)
		begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata = 32'h0;
			st_nxt.rdv = rxq_valid;
			case (paddr)
				// Empty queue reads zero, not a stale slot
				uartlf_pkg::ADDR_DATA:   st_nxt.prdata = rxq_valid ? {24'h0, rxq_data[7:0]} : 32'h0;
				uartlf_pkg::ADDR_RXSTAT: st_nxt.prdata = {29'h0, st_r.stat};
				uartlf_pkg::ADDR_LFC:    st_nxt.prdata = {25'h0, lfc};
				uartlf_pkg::ADDR_DIVHI:  st_nxt.prdata = {28'h0, st_r.div_hi};
				uartlf_pkg::ADDR_DIVLO:  st_nxt.prdata = {24'h0, st_r.div_lo};
				uartlf_pkg::ADDR_CTRL:   st_nxt.prdata = {31'h0, st_r.en};
				uartlf_pkg::ADDR_FLAG:   st_nxt.prdata = {26'h0, !txq_ready, !rxq_valid,
					st_r.tx_ph != uartlf_pkg::PH_IDLE, 3'h0};
				default:                 st_nxt.pslverr = 1'b1;
			endcase
		end
		// Divisor writes only stage; control write commits all 19 bits
		if (access && pwrite)
		begin
			case (paddr)
				uartlf_pkg::ADDR_DIVLO: st_nxt.div_lo = pwdata[7:0];
				uartlf_pkg::ADDR_DIVHI: st_nxt.div_hi = pwdata[3:0];
				uartlf_pkg::ADDR_LFC:   st_nxt.comb = {pwdata[6:0], st_r.div_hi, st_r.div_lo};
				uartlf_pkg::ADDR_CTRL:  st_nxt.en = pwdata[uartlf_pkg::CTRL_EN];
				default:                st_nxt.en = st_r.en;
			endcase
		end
		// Reading data loads that entry's errors and clears overrun
		if (rx_pop)
		begin
			st_nxt.stat[uartlf_pkg::ST_FERR] = rxq_data[uartlf_pkg::RXE_FERR];
			st_nxt.stat[uartlf_pkg::ST_PERR] = rxq_data[uartlf_pkg::RXE_PERR];
			st_nxt.stat[uartlf_pkg::ST_OVR] = 1'b0;
		end
		// Overrun set wins over the clear by a data read
		if (st_r.rx_push && !rxq_ready)
			st_nxt.stat[uartlf_pkg::ST_OVR] = 1'b1;

		// Receive pin synchroniser; only rxs2 is used
		st_nxt.rxs1 = rxd;
		st_nxt.rxs2 = st_r.rxs1;

		// Transmitter: start, data LSB first, parity, stop bits
		if (tick)
		begin
			if (st_r.tx_ph != uartlf_pkg::PH_IDLE)
				st_nxt.tx_tk = st_r.tx_tk + 4'h1;
			case (st_r.tx_ph)
				uartlf_pkg::PH_IDLE:
				begin
					st_nxt.txd = !brk;
					if (tx_pop)
					begin
						st_nxt.tx_sh = txq_data;
						st_nxt.tx_ph = uartlf_pkg::PH_START;
						st_nxt.tx_tk = 4'h0;
						st_nxt.txd = 1'b0;
					end
				end
				uartlf_pkg::PH_START:
					if (st_r.tx_tk == uartlf_pkg::TK_LAST)
					begin
						st_nxt.tx_ph = uartlf_pkg::PH_DATA;
						st_nxt.tx_bit = 3'h0;
						st_nxt.txd = st_r.tx_sh[0];
					end
				uartlf_pkg::PH_DATA:
					if (st_r.tx_tk == uartlf_pkg::TK_LAST)
					begin
						if (st_r.tx_bit == last_bit)
						begin
							// Parity always sent, whatever the check enable
							st_nxt.tx_ph = uartlf_pkg::PH_PARITY;
							st_nxt.txd = par_bit(st_r.tx_sh, len, even);
						end
						else
						begin
							st_nxt.tx_bit = st_r.tx_bit + 3'h1;
							st_nxt.txd = st_r.tx_sh[st_r.tx_bit + 3'h1];
						end
					end
				uartlf_pkg::PH_PARITY:
					if (st_r.tx_tk == uartlf_pkg::TK_LAST)
					begin
						st_nxt.tx_ph = uartlf_pkg::PH_STOP;
						st_nxt.tx_stop2 = stop2;
						st_nxt.txd = 1'b1;
					end
				uartlf_pkg::PH_STOP:
					if (st_r.tx_tk == uartlf_pkg::TK_LAST)
					begin
						if (st_r.tx_stop2)
							st_nxt.tx_stop2 = 1'b0;
						else
							st_nxt.tx_ph = uartlf_pkg::PH_IDLE;
					end
				default: st_nxt.tx_ph = uartlf_pkg::PH_IDLE;
			endcase
		end

		// Receiver: mid-bit sampling, second stop bit left unchecked
		if (tick)
		begin
			st_nxt.rx_tk = st_r.rx_tk + 4'h1;
			case (st_r.rx_ph)
				uartlf_pkg::PH_IDLE:
					if (st_r.en && !st_r.rxs2)
					begin
						st_nxt.rx_ph = uartlf_pkg::PH_START;
						st_nxt.rx_tk = 4'h0;
					end
				uartlf_pkg::PH_START:
					if (st_r.rx_tk == uartlf_pkg::TK_MID)
					begin
						// Glitch shorter than half a bit is dropped
						st_nxt.rx_ph = st_r.rxs2 ? uartlf_pkg::PH_IDLE : uartlf_pkg::PH_DATA;
						st_nxt.rx_tk = 4'h0;
						st_nxt.rx_bit = 3'h0;
						st_nxt.rx_sh = 8'h00;
					end
				uartlf_pkg::PH_DATA:
					if (st_r.rx_tk == uartlf_pkg::TK_LAST)
					begin
						st_nxt.rx_sh[st_r.rx_bit] = st_r.rxs2;
						st_nxt.rx_bit = st_r.rx_bit + 3'h1;
						if (st_r.rx_bit == last_bit)
							st_nxt.rx_ph = uartlf_pkg::PH_PARITY;
					end
				uartlf_pkg::PH_PARITY:
					if (st_r.rx_tk == uartlf_pkg::TK_LAST)
					begin
						// Parity bit stripped, checked only when enabled
						st_nxt.rx_perr = pchk && (st_r.rxs2 != par_bit(st_r.rx_sh, len, even));
						st_nxt.rx_ph = uartlf_pkg::PH_STOP;
					end
				uartlf_pkg::PH_STOP:
					if (st_r.rx_tk == uartlf_pkg::TK_LAST)
					begin
						st_nxt.rx_word = {!st_r.rxs2, st_r.rx_perr, st_r.rx_sh};
						st_nxt.rx_push = 1'b1;
						st_nxt.rx_ph = uartlf_pkg::PH_IDLE;
					end
				default: st_nxt.rx_ph = uartlf_pkg::PH_IDLE;
			endcase
		end

		// Single entry: request per frame; full FIFO: half-full threshold
		st_nxt.rxreq = fifo_en ? (rxq_level >= uartlf_pkg::FIFO_HALF) : rxq_valid;
		st_nxt.txreq = st_r.en && (fifo_en ? (txq_level <= uartlf_pkg::FIFO_HALF) : !txq_valid);
	end

	// Line idles high from reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.comb <= uartlf_pkg::COMB_RST;
			st_r.txd <= 1'b1;
			st_r.rxs1 <= 1'b1;
			st_r.rxs2 <= 1'b1;
		end
		else if (ce)
			st_r <= st_nxt;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_commit_on_ctrl: assert property (ce && access && pwrite && paddr == uartlf_pkg::ADDR_LFC
		|=> st_r.comb == {$past(pwdata[6:0]), $past(st_r.div_hi), $past(st_r.div_lo)})
		else $error("combined register not loaded on control write");
	a_divisor_staged: assert property (!(access && pwrite && paddr == uartlf_pkg::ADDR_LFC)
		|=> $stable(st_r.comb))
		else $error("combined register changed without control write");
	a_tx_parity_bit: assert property (st_r.tx_ph == uartlf_pkg::PH_PARITY
		|-> st_r.txd == par_bit(st_r.tx_sh, len, even))
		else $error("wrong transmit parity bit");
	a_rx_perr_gated: assert property (st_r.rx_push && st_r.rx_word[uartlf_pkg::RXE_PERR] |-> pchk)
		else $error("parity error flagged with check disabled");
	a_single_entry: assert property (!fifo_en |-> txq_level <= 5'h01 && rxq_level <= 5'h01)
		else $error("single-entry mode holds more than one word");
	a_rx_half_req: assert property (ce && fifo_en && rxq_level >= uartlf_pkg::FIFO_HALF |=> st_r.rxreq)
		else $error("receive request missing at half full");
	a_tx_stop_count: assert property (ce && tick && st_r.tx_ph == uartlf_pkg::PH_PARITY
		&& st_r.tx_tk == uartlf_pkg::TK_LAST |=> st_r.tx_stop2 == stop2 && st_r.txd)
		else $error("stop bit count not taken from stop select");
	a_rx_right_align: assert property (st_r.rx_push |-> (st_r.rx_word[7:0] & ~len_mask(8'hff, len)) == 8'h00)
		else $error("received character not zero filled");
	a_single_rx_req: assert property (ce && !fifo_en && rxq_valid ##1 ce |-> st_r.rxreq)
		else $error("receive request missing for single frame");
endmodule : uartlf_top
`default_nettype wire

// file: verif/uartlf_remote.sv
`timescale 1ns/1ps
`default_nettype none
module uartlf_remote (
	input  wire logic pclk,
	input  wire logic line_in,
	output logic      line_out
);
	int bit_cyc;

	// Line rests high between frames
	initial
	begin
		bit_cyc  = 64;
		line_out = 1'b1;
	end

	// One bit period, changed just after an edge
	task automatic hold_bit(input logic v);
		line_out <= v;
		repeat (bit_cyc) @(posedge pclk);
	endtask : hold_bit

	// Frame toward the port; a low stop value provokes a framing fault
	task automatic send(input logic [7:0] d, input int n, input logic par, input logic stop_v, input int stops);
		hold_bit(1'b0);
		for (int i = 0; i < n; i++)
			hold_bit(d[i]);
		hold_bit(par);
		hold_bit(stop_v);
		for (int i = 1; i < stops; i++)
			hold_bit(1'b1);
		line_out <= 1'b1;
	endtask : send

	// Frame from the port, sampled mid bit; returns at first stop
	task automatic capture(input int n, output logic [7:0] d, output logic par, output logic stp, output longint t0);
		d = 8'h00;
		@(negedge line_in);
		t0 = $time;
		repeat (bit_cyc / 2) @(posedge pclk);
		for (int i = 0; i < n; i++)
		begin
			repeat (bit_cyc) @(posedge pclk);
			d[i] = line_in;
		end
		repeat (bit_cyc) @(posedge pclk);
		par = line_in;
		repeat (bit_cyc) @(posedge pclk);
		stp = line_in;
	endtask : capture

	// Start bit length in ns; caller sends data with bit 0 set
	task automatic start_len(output longint dur);
		longint t0;
		@(negedge line_in);
		t0 = $time;
		@(posedge line_in);
		dur = $time - t0;
	endtask : start_len
endmodule : uartlf_remote
`default_nettype wire

// file: verif/tb_uartlf_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_uartlf_top;
	localparam int PER = 50;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        rxd, txd, rx_req, tx_req, ev, st2, p0, p1, s0, s1, ce;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  d0, d1;
	longint      dur, t0, t1;
	int          miscompares, samples_checked, n;

	uartlf_top u_uartlf_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd(rxd), .txd(txd), .rx_service_request(rx_req), .tx_service_request(tx_req));
	uartlf_remote u_uartlf_remote (.pclk(pclk), .line_in(txd), .line_out(rxd));

	// 20 MHz clock
	always #(PER / 2) pclk = ~pclk;

	task automatic end_of_test();
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// One APB transfer; request held until pready is seen
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the answer or the watchdog ends the wait
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(a, 1'b1, d, q);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(a, 1'b0, 32'h0, q);
		`CHK(q, e)
	endtask : rd_chk

	// Low byte, high nibble, control last, then enable
	task automatic cfg(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] ctl);
		wr(uartlf_pkg::ADDR_DIVLO, lo);
		wr(uartlf_pkg::ADDR_DIVHI, hi);
		wr(uartlf_pkg::ADDR_LFC, ctl);
		wr(uartlf_pkg::ADDR_CTRL, 32'h1);
	endtask : cfg

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : do_reset

	function automatic logic [31:0] lfc(int len, logic pchk, logic even, logic stop2, logic fifo);
		return {25'h0, len[1:0], fifo, stop2, even, pchk, 1'b0};
	endfunction : lfc

	function automatic logic [7:0] mask(int k);
		return 8'hff >> (8 - k);
	endfunction : mask

	// Even select makes the total count of ones even
	function automatic logic par_of(logic [7:0] d, int k, logic even);
		return even ? ^(d & mask(k)) : ~^(d & mask(k));
	endfunction : par_of

	// Receive one frame in single-entry mode and read entry then status
	task automatic rx_case(input logic [31:0] ctl, input int k, input logic [7:0] d, input logic par,
		input logic stop_v, input logic [31:0] exp_d, input logic [31:0] exp_st);
		cfg(32'h0, 32'h0, ctl);
		u_uartlf_remote.send(d, k, par, stop_v, 1 + ctl[3]);
		repeat (8) @(posedge pclk);
		`CHK(rx_req, 1'b1)
		rd_chk(uartlf_pkg::ADDR_DATA, exp_d);
		rd_chk(uartlf_pkg::ADDR_RXSTAT, exp_st);
	endtask : rx_case

	// Span well beyond the slowest start-bit measurement
	initial
	begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		end_of_test();
	end

	initial
	begin
		pclk = 1'b0;
		ce = 1'b1;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		miscompares = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset state and an unmapped place
		rd_chk(uartlf_pkg::ADDR_LFC, 32'h0);
		rd_chk(uartlf_pkg::ADDR_FLAG, 32'h10);
		rd_chk(12'h17c, 32'h0);
		`CHK(err, 1'b1)
		// Staged divisor stays idle until the control write
		wr(uartlf_pkg::ADDR_DIVLO, 32'h01);
		wr(uartlf_pkg::ADDR_CTRL, 32'h1);
		fork
			u_uartlf_remote.start_len(dur);
			wr(uartlf_pkg::ADDR_DATA, 32'h01);
		join
		`CHK(dur, longint'(16 * 4 * PER))
		repeat (600) @(posedge pclk);
		// Clock enable low for 64 cycles stretches the start bit by as much
		fork
			u_uartlf_remote.start_len(dur);
			begin
				wr(uartlf_pkg::ADDR_DATA, 32'h01);
				repeat (16) @(posedge pclk);
				ce <= 1'b0;
				repeat (64) @(posedge pclk);
				ce <= 1'b1;
			end
		join
		`CHK(dur, longint'(16 * 4 * 2 * PER))
		repeat (600) @(posedge pclk);
		wr(uartlf_pkg::ADDR_LFC, 32'h0);
		fork
			u_uartlf_remote.start_len(dur);
			wr(uartlf_pkg::ADDR_DATA, 32'h01);
		join
		`CHK(dur, longint'(16 * 4 * 2 * PER))
		// High nibble lands in divisor bits 11:8
		do_reset();
		cfg(32'h0, 32'h1, 32'h0);
		fork
			u_uartlf_remote.start_len(dur);
			wr(uartlf_pkg::ADDR_DATA, 32'h01);
		join
		`CHK(dur, longint'(16 * 4 * 257 * PER))
		do_reset();
		// Every length code, both parities, both stop counts, back to back
		for (int k = 0; k < 8; k++)
		begin
			n = 5 + k / 2;
			ev = k[0];
			st2 = k[0] ^ k[1];
			cfg(32'h0, 32'h0, lfc(k / 2, 1'b0, ev, st2, 1'b1));
			fork
				begin
					u_uartlf_remote.capture(n, d0, p0, s0, t0);
					u_uartlf_remote.capture(n, d1, p1, s1, t1);
				end
				begin
					wr(uartlf_pkg::ADDR_DATA, 32'ha5);
					wr(uartlf_pkg::ADDR_DATA, 32'h5a);
				end
			join
			`CHK(d0, 8'ha5 & mask(n))
			`CHK(d1, 8'h5a & mask(n))
			`CHK(p0, par_of(8'ha5, n, ev))
			`CHK(p1, par_of(8'h5a, n, ev))
			`CHK(s0, 1'b1)
			`CHK(s1, 1'b1)
			// Next frame starts one idle tick after the last stop bit
			`CHK(t1 - t0, longint'(((3 + n + st2) * 64 + 4) * PER))
			repeat (200) @(posedge pclk);
		end
		// Receive side: good, bad parity, check off, short char, framing
		rx_case(lfc(3, 1'b1, 1'b1, 1'b0, 1'b0), 8, 8'h3c, 1'b0, 1'b1, 32'h3c, 32'h0);
		rx_case(lfc(3, 1'b1, 1'b1, 1'b0, 1'b0), 8, 8'h3c, 1'b1, 1'b1, 32'h3c, 32'h2);
		rx_case(lfc(3, 1'b0, 1'b1, 1'b0, 1'b0), 8, 8'h3c, 1'b1, 1'b1, 32'h3c, 32'h0);
		rx_case(lfc(0, 1'b1, 1'b0, 1'b0, 1'b0), 5, 8'hff, par_of(8'hff, 5, 1'b0), 1'b1, 32'h1f, 32'h0);
		rx_case(lfc(2, 1'b1, 1'b1, 1'b0, 1'b0), 7, 8'h55, par_of(8'h55, 7, 1'b1), 1'b0, 32'h55, 32'h1);
		rx_case(lfc(1, 1'b1, 1'b0, 1'b1, 1'b0), 6, 8'h2a, par_of(8'h2a, 6, 1'b0), 1'b0, 32'h2a, 32'h1);
		// Full depth: request only at half full, then drain in order
		cfg(32'h0, 32'h0, lfc(3, 1'b0, 1'b0, 1'b0, 1'b1));
		repeat (2) @(posedge pclk);
		`CHK(tx_req, 1'b1)
		for (int i = 0; i < 8; i++)
		begin
			`CHK(rx_req, 1'b0)
			u_uartlf_remote.send(8'(i), 8, par_of(8'(i), 8, 1'b0), 1'b1, 1);
			repeat (8) @(posedge pclk);
		end
		`CHK(rx_req, 1'b1)
		for (int i = 0; i < 8; i++)
			rd_chk(uartlf_pkg::ADDR_DATA, 32'(i));
		rd_chk(uartlf_pkg::ADDR_FLAG, 32'h10);
		end_of_test();
	end
endmodule : tb_uartlf_top
`default_nettype wire
